// file: verilog/acoc_top.sv
// Implementation choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
// Function
// - Trigger sense field picks level, falling, rising or either edge for the ADC event.
// - In level mode the interrupt asks while output equals the interrupt level bit.
// - Interrupt sense field picks level, falling, rising or either edge.
// - Invert bit flips the comparator output before all sensing.
// - Control bit 0 reads zero and every field resets to zero.
// - In level mode the ADC event stands while output equals the trigger level bit.
// - The ADC event leaves only when the event enable bit is set.
module acoc_top
  import acoc_pkg::*;
(
  input wire logic i_core_clk, // 250 MHz clock
  input wire logic i_reset, // Async reset, high
  input wire logic i_cmp_out, // Raw comparator output
  input wire logic [3:0] i_address, // Avalon byte address
  input wire logic i_read, // Avalon read
  input wire logic i_write, // Avalon write
  input wire logic [31:0] i_writedata, // Avalon write data
  input wire logic [3:0] i_byteenable, // Avalon byte enables
  output logic [31:0] o_readdata, // Avalon read data
  output logic o_waitrequest, // Avalon wait
  output logic o_irq, // Level interrupt
  output logic o_adc_event // Event to ADC trigger
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic out;
    logic [31:0] ctrl;
    logic [1:0] stat;
    logic [1:0] ien;
    logic ack;
    logic wreq;
    logic [31:0] rdata;
    logic irq;
    logic adc;
  } acoc_state_t;

  acoc_state_t q, d;
  logic [31:0] be_mask;
  logic cond;
  logic irq_hit;
  logic adc_hit;

  acoc_sense_if irq_if ();
  acoc_sense_if adc_if ();

  // Condition the synchronised output; edges use last cycle's value
  assign cond = q.sync2 ^ q.ctrl[ACOC_B_INV];
  assign irq_if.level = cond;
  assign irq_if.rise = cond & ~q.out;
  assign irq_if.fall = ~cond & q.out;
  assign irq_if.mode = q.ctrl[ACOC_B_IRQ_MODE_LO +: 2];
  assign irq_if.polarity = q.ctrl[ACOC_B_ISLV];
  assign adc_if.level = cond;
  assign adc_if.rise = cond & ~q.out;
  assign adc_if.fall = ~cond & q.out;
  assign adc_if.mode = q.ctrl[ACOC_B_TRIG_MODE_LO +: 2];
  assign adc_if.polarity = q.ctrl[ACOC_B_TSLV];
  assign irq_hit = irq_if.hit;
  assign adc_hit = adc_if.hit;

  acoc_sense u_irq_sense (.s(irq_if));
  acoc_sense u_adc_sense (.s(adc_if));

  // Byte lane mask from the enables
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      be_mask[i*8 +: 8] = {8{i_byteenable[i]}};
    end
  end

  // Next state: one-cycle wait then ack per access
  always_comb begin
    d = q;
    d.sync1 = i_cmp_out;
    d.sync2 = q.sync1;
    d.out = cond;
    d.ack = 1'b0;
    d.adc = adc_hit & q.ctrl[ACOC_B_ADC_EN];
    if ((i_read || i_write) && !q.ack) begin
      d.ack = 1'b1;
      if (i_write) begin
        if (i_address == ACOC_OFF_CTRL) begin
          d.ctrl = ((q.ctrl & ~be_mask) | (i_writedata & be_mask)) & ACOC_CTRL_MASK;
        end else if (i_address == ACOC_OFF_IEN) begin
          d.ien = (q.ien & ~be_mask[1:0]) | (i_writedata[1:0] & be_mask[1:0]);
        end else if (i_address == ACOC_OFF_ICLR) begin
          d.stat = q.stat & ~(i_writedata[1:0] & be_mask[1:0]);
        end
      end else begin
        if (i_address == ACOC_OFF_CTRL) begin
          d.rdata = q.ctrl;
        end else if (i_address == ACOC_OFF_STAT) begin
          d.rdata = {29'h0000_0000, cond, q.stat};
        end else if (i_address == ACOC_OFF_IEN) begin
          d.rdata = {30'h0000_0000, q.ien};
        end else begin
          d.rdata = 32'h0000_0000;
        end
      end
    end
    // Set wins over a same-cycle clear
    if (irq_hit) begin
      d.stat[ACOC_ST_IRQ] = 1'b1;
    end
    if (adc_hit) begin
      d.stat[ACOC_ST_ADC] = 1'b1;
    end
    d.irq = |(d.stat & d.ien);
    d.wreq = ~d.ack; // Kept as a flop so the pin needs no inverter
  end

  // State register
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      q <= '0;
      q.ctrl <= ACOC_CTRL_RST;
      q.wreq <= 1'b1; // Hold off the bus while in reset
    end else begin
      q <= d;
    end
  end

  assign o_readdata = q.rdata;
  assign o_waitrequest = q.wreq;
  assign o_irq = q.irq;
  assign o_adc_event = q.adc;

  // Checks
  // Output went from low to high across the last two samples
  sequence rise_seen_s;
    !q.out ##1 q.out;
  endsequence

  // Output differs from last cycle, so an edge stands in this cycle
  sequence change_now_s;
    cond != q.out;
  endsequence

  // Bus request that the slave has not answered yet
  sequence req_new_s;
    (i_read || i_write) && o_waitrequest;
  endsequence

  // Answer: waitrequest low for one cycle, then high again
  sequence ack_pulse_s;
    !o_waitrequest ##1 o_waitrequest;
  endsequence

  // Control register: reserved bits stay zero, fields clear on reset
  ctrl_bit0_zero_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (q.ctrl & ~ACOC_CTRL_MASK) == 32'h0000_0000) else $error("control reserved bits set");
  reset_zero_a: assert property (@(posedge i_core_clk)
    $fell(i_reset) |-> (q.ctrl == ACOC_CTRL_RST && q.ien == 2'h0))
    else $error("control not cleared by reset");
  ctrl_read_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_read && o_waitrequest && i_address == ACOC_OFF_CTRL)
    |=> (o_readdata & ~ACOC_CTRL_MASK) == 32'h0000_0000)
    else $error("reserved control bits read back set");

  // Inversion sits ahead of both sense paths
  invert_path_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    cond == ($past(q.sync1) ^ q.ctrl[ACOC_B_INV])) else $error("invert wrong");

  // Level sense on the interrupt path: sticky bit follows a matching output
  irq_level_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (irq_if.mode == ACOC_SENSE_LEVEL && cond == q.ctrl[ACOC_B_ISLV])
    |=> q.stat[ACOC_ST_IRQ])
    else $error("level irq missed");

  // Level sense on the ADC path, both polarities
  adc_level_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (adc_if.mode == ACOC_SENSE_LEVEL && cond == q.ctrl[ACOC_B_TSLV]
    && q.ctrl[ACOC_B_ADC_EN]) |=> o_adc_event) else $error("level adc event missed");
  adc_level_off_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (adc_if.mode == ACOC_SENSE_LEVEL && cond != q.ctrl[ACOC_B_TSLV])
    |=> !o_adc_event) else $error("level adc event on wrong polarity");

  // Enable gate: a cleared enable bit keeps the ADC quiet
  adc_gate_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    !$past(q.ctrl[ACOC_B_ADC_EN]) |-> !o_adc_event) else $error("adc event leaked");

  // Interrupt edge modes
  irq_rise_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (irq_if.mode == ACOC_SENSE_RISE && cond && !q.out) |=> q.stat[ACOC_ST_IRQ])
    else $error("rise irq missed");
  irq_fall_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (irq_if.mode == ACOC_SENSE_FALL && !cond && q.out) |=> q.stat[ACOC_ST_IRQ])
    else $error("fall irq missed");
  irq_both_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (irq_if.mode == ACOC_SENSE_BOTH) ##0 change_now_s |=> q.stat[ACOC_ST_IRQ])
    else $error("either edge irq missed");

  // ADC edge modes, with the enable set
  adc_rise_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (adc_if.mode == ACOC_SENSE_RISE && q.ctrl[ACOC_B_ADC_EN] && cond && !q.out)
    |=> o_adc_event) else $error("rise adc event missed");
  adc_fall_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (adc_if.mode == ACOC_SENSE_FALL && q.ctrl[ACOC_B_ADC_EN] && !cond && q.out)
    |=> o_adc_event) else $error("fall adc event missed");
  adc_both_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (adc_if.mode == ACOC_SENSE_BOTH && q.ctrl[ACOC_B_ADC_EN]) ##0 change_now_s
    |=> o_adc_event) else $error("either edge adc event missed");

  // Edge events last one cycle and never come without an edge
  edge_pulse_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (adc_if.mode == ACOC_SENSE_RISE && q.ctrl[ACOC_B_ADC_EN] && $stable(q.ctrl))
    ##0 rise_seen_s ##1 $stable(cond) |-> !o_adc_event) else $error("edge held too long");
  adc_quiet_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (adc_if.mode != ACOC_SENSE_LEVEL && cond == q.out) |=> !o_adc_event)
    else $error("adc event without an edge");

  // Bus: one wait state, then waitrequest low for exactly one cycle
  bus_answer_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    req_new_s |=> ack_pulse_s) else $error("bus answer wrong");

  // Interrupt output: high exactly while an enabled sticky bit is set
  irq_out_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    o_irq == |(q.stat & q.ien)) else $error("irq output wrong");

  // A clear lands unless a new event arrives in the same cycle
  stat_clear_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_write && o_waitrequest && i_address == ACOC_OFF_ICLR && i_writedata[ACOC_ST_IRQ]
    && i_byteenable[0] && !irq_hit) |=> !q.stat[ACOC_ST_IRQ]) else $error("clear lost");
endmodule

// file: verilog/acoc_pkg.sv
package acoc_pkg;
  // Register byte offsets (word aligned)
  localparam logic [3:0] ACOC_OFF_CTRL = 4'h0;
  localparam logic [3:0] ACOC_OFF_STAT = 4'h4;
  localparam logic [3:0] ACOC_OFF_IEN = 4'h8;
  localparam logic [3:0] ACOC_OFF_ICLR = 4'hC;
  // Control field positions
  localparam int ACOC_B_INV = 1;
  localparam int ACOC_B_IRQ_MODE_LO = 2;
  localparam int ACOC_B_ISLV = 4;
  localparam int ACOC_B_TRIG_MODE_LO = 5;
  localparam int ACOC_B_TSLV = 7;
  localparam int ACOC_B_ADC_EN = 11;
  // Writable control bits: 11, 7:1; bit 0 and the rest stay zero
  localparam logic [31:0] ACOC_CTRL_MASK = 32'h0000_08FE;
  localparam logic [31:0] ACOC_CTRL_RST = 32'h0000_0000;
  // Status: bit0 interrupt event, bit1 adc event, bit2 live conditioned output
  localparam int ACOC_ST_IRQ = 0;
  localparam int ACOC_ST_ADC = 1;
  localparam int ACOC_ST_OUT = 2;
  typedef enum logic [1:0] {
    ACOC_SENSE_LEVEL = 2'b00,
    ACOC_SENSE_FALL = 2'b01,
    ACOC_SENSE_RISE = 2'b10,
    ACOC_SENSE_BOTH = 2'b11
  } acoc_sense_t;
endpackage

// file: verilog/acoc_sense_if.sv
`timescale 1ns/1ps
interface acoc_sense_if;
  logic level;
  logic rise;
  logic fall;
  logic [1:0] mode;
  logic polarity;
  logic hit;
  modport src (output level, output rise, output fall, output mode, output polarity,
    input hit);
  modport det (input level, input rise, input fall, input mode, input polarity,
    output hit);
endinterface

// file: verilog/acoc_sense.sv
`timescale 1ns/1ps
module acoc_sense
  import acoc_pkg::*;
(
  acoc_sense_if.det s // One sense path
);
  // Pick the selected condition
  always_comb begin
    case (acoc_sense_t'(s.mode))
      ACOC_SENSE_LEVEL: s.hit = (s.level == s.polarity);
      ACOC_SENSE_FALL: s.hit = s.fall;
      ACOC_SENSE_RISE: s.hit = s.rise;
      default: s.hit = s.rise | s.fall;
    endcase
  end
endmodule

// file: verification/acoc_adc_model.sv
`timescale 1ns/1ps
// ADC trigger input: counts cycles with the event high
module acoc_adc_model (
  input wire logic i_core_clk, // Clock
  input wire logic i_reset, // Async reset
  input wire logic i_adc_event, // Event from block
  output logic [7:0] o_count // Events seen
);
  // Wraps; tests only use small differences
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) o_count <= 8'h00;
    else if (i_adc_event === 1'b1) o_count <= o_count + 8'h01;
  end
endmodule

// file: verification/acoc_top_test.sv
`timescale 1ns/1ps
module acoc_top_test;
  import acoc_pkg::*;
  logic clk = 0, rst = 1, cmp = 0, rd = 0, wr = 0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0, rdata;
  logic wreq, irq, adc;
  logic [7:0] cnt, c0;
  logic [31:0] expq[$];
  int fail_count = 0, cmp_count = 0, seed = 32'hA1F5, v;
  acoc_top u_acoc_top (.i_core_clk(clk), .i_reset(rst), .i_cmp_out(cmp), .i_address(adr),
    .i_read(rd), .i_write(wr), .i_writedata(wd), .i_byteenable(4'hF), .o_readdata(rdata),
    .o_waitrequest(wreq), .o_irq(irq), .o_adc_event(adc));
  acoc_adc_model u_acoc_adc_model (.i_core_clk(clk), .i_reset(rst), .i_adc_event(adc),
    .o_count(cnt));
  initial forever #2 clk = ~clk;
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Held until waitrequest is sampled low, released after that edge
  task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk); while (wreq !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task rdx(input logic [3:0] a, input logic [31:0] e);
    expq.push_back(e);
    acc(1'b0, a, 32'h0);
  endtask
  // Scoreboard: oldest note against each completed read
  always @(posedge clk) if (rd && wreq === 1'b0) chk("readdata", expq.pop_front(), rdata);
  // Watchdog well past the expected run
  initial begin
    #20000;
    fail_count++;
    end_sim;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdx(ACOC_OFF_CTRL, 32'h0);
    v = $random(seed);
    acc(1'b1, ACOC_OFF_CTRL, v);
    rdx(ACOC_OFF_CTRL, v & ACOC_CTRL_MASK);
    $display("test registers done");
    // Level sense: interrupt polarity high, trigger polarity low
    acc(1'b1, ACOC_OFF_IEN, 32'h1);
    acc(1'b1, ACOC_OFF_CTRL, 32'h10);
    repeat (6) @(posedge clk);
    acc(1'b1, ACOC_OFF_ICLR, 32'h3);
    rdx(ACOC_OFF_STAT, 32'h2);
    chk("irq", 32'h0, {31'h0, irq});
    cmp <= 1'b1;
    repeat (6) @(posedge clk);
    rdx(ACOC_OFF_STAT, 32'h7);
    chk("irq", 32'h1, {31'h0, irq});
    $display("test level done");
    // Every edge mode, without and with inversion; one high pulse each
    for (v = 1; v < 8; v++) begin
      if (v[1:0] == 2'b00) continue;
      cmp <= v[2];
      acc(1'b1, ACOC_OFF_CTRL, {20'h0, 1'b1, 4'h0, v[1:0], 1'b0, v[1:0], v[2], 1'b0});
      repeat (6) @(posedge clk);
      acc(1'b1, ACOC_OFF_ICLR, 32'h3);
      c0 = cnt;
      rdx(ACOC_OFF_STAT, 32'h0);
      cmp <= !v[2];
      repeat (6) @(posedge clk);
      cmp <= v[2];
      repeat (6) @(posedge clk);
      chk("adc count", (v[1:0] == 2'b11) ? 32'h2 : 32'h1, {24'h0, cnt - c0});
      rdx(ACOC_OFF_STAT, 32'h3);
      chk("irq", 32'h1, {31'h0, irq});
    end
    // Event enable off: nothing reaches the ADC
    acc(1'b1, ACOC_OFF_CTRL, 32'h60);
    c0 = cnt;
    cmp <= !cmp;
    repeat (6) @(posedge clk);
    chk("adc count", 32'h0, {24'h0, cnt - c0});
    $display("test sensing done");
    end_sim;
  end
endmodule
